// ==== shared/sysfront_pkg.sv ====
// Purpose: Shared constants and carriers for the reset, clock and fetch strobe front end.
// Assumes: core_clk at 10 MHz stands in for the oscillator input.
// Notes: One machine cycle is twelve oscillator periods, six phase-clock periods.
package sysfront_pkg;
  localparam int          OSC_PER_MC      = 12;
  localparam int          PH_PER_MC       = OSC_PER_MC / 2;
  localparam logic [2:0]  PH_LAST         = 3'h5;
  localparam logic [2:0]  PH_ALE_A        = 3'h0;
  localparam logic [2:0]  PH_ALE_B        = 3'h3;
  localparam logic [2:0]  PH_FETCH        = 3'h1;
  localparam int          RST_MIN_OSC     = 24;
  localparam logic [4:0]  RST_MIN_CNT     = 5'h18;
  localparam logic [4:0]  WDT_PULSE_CNT   = 5'h18;
  localparam logic [15:0] INT_ROM_LIMIT   = 16'h2000;

  // Pin-level fetch and strobe outputs.
  typedef struct packed {
    logic ale;
    logic program_fetch_strobe_n;
    logic fetch_external;
  } strobe_bus_t;
endpackage

// ==== rtl/sync2.sv ====
// Purpose: Two flip-flop synchroniser for asynchronous pin levels.
// Assumes: One clock; asynchronous active-low reset.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/1ps
module sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Level in and out.
  input  wire logic d,
  output logic      q
);
  logic meta_r;

  // Two stages clocked back to back.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// ==== rtl/sysfront.sv ====
// Purpose: Reset qualification, clock division and fetch strobes of an 8-bit controller.
// Assumes: core_clk is the oscillator input; the pins arrive asynchronously.
// Notes: The reset pin is shared: input, output and active-low output enable.
// Summary of operation
// RULE1 - The oscillator input is halved by a toggle flop before any timing uses it; the reset and watchdog counts here run on the undivided clock.
// RULE2 - The board must hold the reset pin high for 24 oscillator periods to reset the device.
// RULE3 - At power-on the board holds reset through oscillator start-up plus two machine cycles.
// RULE4 - A watchdog timer overflow drives a reset pulse out on the reset pin.
// RULE5 - The address-latch strobe pulses once every six oscillator periods.
// RULE6 - One address-latch strobe pulse is dropped in each external data memory cycle.
// RULE7 - With fetch select high, program counters below 8192 fetch from internal memory.
// RULE8 - With fetch select low, every fetch goes to external memory.
// RULE9 - The program-fetch strobe goes low for each external instruction byte read.
// RULE10 - Fetch select is sampled during reset and ignored after release.
// RULE11 - A high watchdog enable pin enables the watchdog and blocks power-down.
// RULE12 - A machine cycle is twelve oscillator periods with two strobe pulses.
`timescale 1ns/1ps
module sysfront (
  // Clock and reset.
  input  wire logic                      core_clk,
  input  wire logic                      reset_n,
  // Pins.
  input  wire logic                      reset_pin_in,
  output logic                           reset_pin_out,
  output logic                           reset_pin_oe_n,
  input  wire logic                      external_fetch_select,
  input  wire logic                      watchdog_enable_pin,
  output logic                           oscillator_output,
  // Core side.
  input  wire logic [15:0]               program_counter,
  input  wire logic                      fetch_request,
  input  wire logic                      data_access,
  input  wire logic                      watchdog_timer_overflow,
  input  wire logic                      power_down_request,
  output logic                           core_reset,
  output logic                           watchdog_active,
  output logic                           power_down_allowed,
  output logic                           phase_clk,
  output logic [2:0]                     machine_phase,
  output sysfront_pkg::strobe_bus_t      strobes
);
  typedef struct packed {
    logic       div;
    logic [2:0] phase;
    logic [4:0] rst_cnt;
    logic       in_reset;
    logic       fetch_sel;
    logic [4:0] wdt_cnt;
    sysfront_pkg::strobe_bus_t st;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic   rst_pin_s;
  logic   fsel_s;
  logic   wden_s;
  logic   int_fetch;

  sync2 #(.RST_VAL(1'b1)) u_rst (.core_clk(core_clk), .reset_n(reset_n),
                                 .d(reset_pin_in), .q(rst_pin_s));
  sync2 #(.RST_VAL(1'b0)) u_fsel (.core_clk(core_clk), .reset_n(reset_n),
                                  .d(external_fetch_select), .q(fsel_s));
  sync2 #(.RST_VAL(1'b1)) u_wden (.core_clk(core_clk), .reset_n(reset_n),
                                  .d(watchdog_enable_pin), .q(wden_s));

  // Internal fetch only when latched select is high and below the internal limit.
  assign int_fetch = st_r.fetch_sel && (program_counter < sysfront_pkg::INT_ROM_LIMIT); // RULE7 RULE8

  // Next-state logic for divider, phases, reset and strobes.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.div = ~st_r.div; // RULE1
    if (st_r.div)
    begin
      st_nxt.phase = (st_r.phase == sysfront_pkg::PH_LAST) ? 3'h0 : st_r.phase + 3'h1; // RULE12
    end
    // Count reset pin high time in oscillator periods.
    if (rst_pin_s && st_r.wdt_cnt == 5'h00)
    begin
      if (st_r.rst_cnt != sysfront_pkg::RST_MIN_CNT)
      begin
        st_nxt.rst_cnt = st_r.rst_cnt + 5'h01; // RULE2
      end
      // The edge that completes the minimum count already enters reset.
      if (st_nxt.rst_cnt == sysfront_pkg::RST_MIN_CNT)
      begin
        st_nxt.in_reset = 1'b1; // RULE2
      end
    end
    else if (!rst_pin_s)
    begin
      st_nxt.rst_cnt  = 5'h00;
      st_nxt.in_reset = 1'b0;
    end
    if (st_r.in_reset)
    begin
      st_nxt.fetch_sel = fsel_s; // RULE10
    end
    // Watchdog overflow launches an outgoing reset pulse of two machine cycles.
    if (st_r.wdt_cnt != 5'h00)
    begin
      st_nxt.wdt_cnt  = st_r.wdt_cnt - 5'h01;
      st_nxt.in_reset = 1'b1;
    end
    else if (watchdog_timer_overflow && wden_s && !st_r.in_reset)
    begin
      st_nxt.wdt_cnt = sysfront_pkg::WDT_PULSE_CNT; // RULE4
    end
    // Strobes advance on the divided clock edge.
    if (st_r.div)
    begin
      st_nxt.st.ale = !st_r.in_reset &&
                      (st_nxt.phase == sysfront_pkg::PH_ALE_A ||
                       st_nxt.phase == sysfront_pkg::PH_ALE_B) &&
                      !(data_access && st_nxt.phase == sysfront_pkg::PH_ALE_A); // RULE5 RULE6
      st_nxt.st.fetch_external = !int_fetch;
      st_nxt.st.program_fetch_strobe_n =
        !(!st_r.in_reset && fetch_request && !int_fetch &&
          st_nxt.phase == sysfront_pkg::PH_FETCH); // RULE9
    end
  end

  // Single state register.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= '{div: 1'b0, phase: 3'h0, rst_cnt: 5'h00, in_reset: 1'b1,
                fetch_sel: 1'b0, wdt_cnt: 5'h00,
                st: '{ale: 1'b0, program_fetch_strobe_n: 1'b1, fetch_external: 1'b1}};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs.
  assign reset_pin_out      = 1'b1;
  assign reset_pin_oe_n     = (st_r.wdt_cnt == 5'h00); // RULE4
  assign oscillator_output  = st_r.div;
  assign phase_clk          = st_r.div;
  assign machine_phase      = st_r.phase;
  assign core_reset         = st_r.in_reset;
  assign watchdog_active    = wden_s; // RULE11
  assign power_down_allowed = !wden_s && power_down_request; // RULE11
  assign strobes            = st_r.st;

  // Divider toggles every edge.
  property p_div;
    @(posedge core_clk) disable iff (!reset_n)
      $past(reset_n) |-> st_r.div != $past(st_r.div);
  endproperty
  a_div: assert property (p_div) else $error("divider failed to toggle"); // RULE1

  // A watchdog start drives the pin for at least eight clocks.
  property p_wdt;
    @(posedge core_clk) disable iff (!reset_n)
      $rose(!reset_pin_oe_n) |-> (!reset_pin_oe_n)[*8];
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog pulse too short"); // RULE4

  // Strobe pulses stand two clocks and start at least six oscillator periods apart.
  property p_ale;
    @(posedge core_clk) disable iff (!reset_n)
      $rose(strobes.ale) |=> strobes.ale ##1 (!strobes.ale)[*4];
  endproperty
  a_ale: assert property (p_ale) else $error("strobe spacing wrong"); // RULE5

  // Fetch strobe never asserted for internal fetches.
  property p_fetch;
    @(posedge core_clk) disable iff (!reset_n)
      !strobes.program_fetch_strobe_n |-> strobes.fetch_external;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch strobe on internal fetch"); // RULE9

  // Latched select holds outside reset.
  property p_fsel;
    @(posedge core_clk) disable iff (!reset_n)
      !st_r.in_reset && !$past(st_r.in_reset) |-> $stable(st_r.fetch_sel);
  endproperty
  a_fsel: assert property (p_fsel) else $error("fetch select changed after reset"); // RULE10

  // Power-down is blocked while the watchdog pin is high, two flops late.
  property p_pd;
    @(posedge core_clk) disable iff (!reset_n)
      power_down_allowed |-> !$past(watchdog_enable_pin, 2);
  endproperty
  a_pd: assert property (p_pd) else $error("power-down allowed wrongly"); // RULE11

  // Phase advances only once per two oscillator edges.
  property p_phase;
    @(posedge core_clk) disable iff (!reset_n)
      !$past(st_r.div) |-> $stable(st_r.phase);
  endproperty
  a_phase: assert property (p_phase) else $error("phase moved early"); // RULE12

  // External select low forces external fetch.
  property p_ext;
    @(posedge core_clk) disable iff (!reset_n)
      $past(st_r.div) && !$past(st_r.fetch_sel) |-> strobes.fetch_external;
  endproperty
  a_ext: assert property (p_ext) else $error("internal fetch with select low"); // RULE8

  // A reset pin held high for the minimum time puts the core into reset.
  property p_rst_min;
    @(posedge core_clk) disable iff (!reset_n)
      rst_pin_s && st_r.wdt_cnt == 5'h00 &&
      st_r.rst_cnt == sysfront_pkg::RST_MIN_CNT - 5'h01 |=> core_reset;
  endproperty
  a_rst_min: assert property (p_rst_min) else $error("minimum reset pulse not taken"); // RULE2

  // A driven reset pin always resets the core on the next edge.
  property p_wdt_rst;
    @(posedge core_clk) disable iff (!reset_n) !reset_pin_oe_n |=> core_reset;
  endproperty
  a_wdt_rst: assert property (p_wdt_rst) else $error("drive without core reset"); // RULE4

  // The program-fetch strobe only stands in the fetch phase.
  property p_pfs_phase;
    @(posedge core_clk) disable iff (!reset_n)
      !strobes.program_fetch_strobe_n |-> machine_phase == sysfront_pkg::PH_FETCH;
  endproperty
  a_pfs_phase: assert property (p_pfs_phase) else $error("fetch strobe off phase"); // RULE9

  // A data access drops the strobe pulse of the first strobe phase.
  property p_skip;
    @(posedge core_clk) disable iff (!reset_n)
      $past(st_r.div) && $past(data_access) && machine_phase == sysfront_pkg::PH_ALE_A
        |-> !strobes.ale;
  endproperty
  a_skip: assert property (p_skip) else $error("strobe not dropped on data access"); // RULE6
endmodule

// ==== testbench/board_model.sv ====
// Purpose: Board side of the reset pin: power-on hold, manual hold and pull-down.
// Assumes: The device drives the pin only while its active-low enable is low.
// Notes: A released pin falls to the pull-down level.
`timescale 1ns/1ps
module board_model (
  // Clock.
  input  wire logic core_clk,
  // Reset pin parties.
  input  wire logic reset_pin_out,
  input  wire logic reset_pin_oe_n,
  input  wire logic hold_reset,
  output logic      reset_pin_in
);
  logic [5:0] por_cnt_r = 6'h00;

  // Power-on hold covers oscillator start-up plus two machine cycles.
  always @(posedge core_clk)
    if (por_cnt_r != 6'h28)
      por_cnt_r <= por_cnt_r + 6'h01;

  // Wire level from device drive, board drive and the pull-down.
  assign reset_pin_in = (!reset_pin_oe_n && reset_pin_out) || hold_reset
                        || (por_cnt_r != 6'h28);
endmodule

// ==== testbench/test_sysfront.sv ====
// Purpose: Self-checking bench for the reset, clock and fetch strobe front end.
// Assumes: The board model supplies the reset pin level.
// Notes: Strobes are counted over whole machine cycles.
`timescale 1ns/1ps
module test_sysfront;
  logic                      core_clk, reset_n, hold_reset, pin_in, pin_out, oe_n;
  logic                      efs, wd_pin, osc_out, fetch_req, data_acc, ovf, pd_req;
  logic                      core_reset, wd_act, pd_ok, ph_clk;
  logic [2:0]                ph;
  logic [15:0]               pc;
  sysfront_pkg::strobe_bus_t strobes;
  int                        n_mismatch = 0;
  int                        tests_run = 0;
  int                        n_ale, n_pfs, n_oe, n_rst;

  sysfront u_dut (.core_clk(core_clk), .reset_n(reset_n), .reset_pin_in(pin_in),
    .reset_pin_out(pin_out), .reset_pin_oe_n(oe_n), .external_fetch_select(efs),
    .watchdog_enable_pin(wd_pin), .oscillator_output(osc_out), .program_counter(pc),
    .fetch_request(fetch_req), .data_access(data_acc), .watchdog_timer_overflow(ovf),
    .power_down_request(pd_req), .core_reset(core_reset), .watchdog_active(wd_act),
    .power_down_allowed(pd_ok), .phase_clk(ph_clk), .machine_phase(ph), .strobes(strobes));

  board_model u_board (.core_clk(core_clk), .reset_pin_out(pin_out),
    .reset_pin_oe_n(oe_n), .hold_reset(hold_reset), .reset_pin_in(pin_in));

  // Clock of 100 ns period.
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #10;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask

  // Counts strobe and fetch pulse starts, drive cycles and reset cycles over a window.
  task automatic watch(input int n);
    logic pa;
    logic pp;
    pa = strobes.ale;
    pp = strobes.program_fetch_strobe_n;
    n_ale = 0;
    n_pfs = 0;
    n_oe = 0;
    n_rst = 0;
    repeat (n)
    begin
      tick(1);
      n_ale += int'(strobes.ale === 1'b1 && pa === 1'b0);
      n_pfs += int'(strobes.program_fetch_strobe_n === 1'b0 && pp === 1'b1);
      n_oe += int'(oe_n === 1'b0);
      n_rst += int'(core_reset === 1'b1);
      pa = strobes.ale;
      pp = strobes.program_fetch_strobe_n;
    end
  endtask

  task automatic do_reset(input logic fsel, input logic wd);
    efs = fsel;
    wd_pin = wd;
    reset_n = 1'b0;
    tick(10);
    reset_n = 1'b1;
    tick(40);
    chk("core_reset", 16'h0000, {15'h0, core_reset});
  endtask

  task automatic t_clock();
    logic       prev;
    logic [2:0] p0;
    logic [2:0] p1;
    prev = osc_out;
    tick(1);
    chk("osc_out", {15'h0, ~prev}, {15'h0, osc_out});
    chk("phase_clk", {15'h0, ~prev}, {15'h0, ph_clk});
    p0 = ph;
    p1 = (p0 == sysfront_pkg::PH_LAST) ? 3'h0 : p0 + 3'h1;
    tick(2);
    chk("machine_phase", {13'h0, p1}, {13'h0, ph});
    watch(24);
    chk("ale_count", 16'h0004, n_ale[15:0]);
    data_acc = 1'b1;
    tick(12);
    watch(24);
    chk("ale_skip", 16'h0002, n_ale[15:0]);
    data_acc = 1'b0;
  endtask

  task automatic t_fetch(input logic [15:0] addr, input logic [15:0] exp_pfs);
    pc = addr;
    fetch_req = 1'b1;
    tick(12);
    watch(24);
    fetch_req = 1'b0;
    chk("fetch_strobe_count", exp_pfs, n_pfs[15:0]);
    chk("fetch_external", {15'h0, exp_pfs != 16'h0}, {15'h0, strobes.fetch_external});
    tick(12);
  endtask

  task automatic t_wdog(input logic wd, input logic [15:0] exp_oe);
    logic first_low;
    pd_req = 1'b1;
    tick(4);
    chk("watchdog_active", {15'h0, wd}, {15'h0, wd_act});
    chk("power_down_allowed", {15'h0, ~wd}, {15'h0, pd_ok});
    pd_req = 1'b0;
    ovf = 1'b1;
    tick(1);
    ovf = 1'b0;
    first_low = (oe_n === 1'b0);
    watch(40);
    chk("drive_cycles", exp_oe, n_oe[15:0] + {15'h0, first_low});
    chk("core_reset_seen", {15'h0, wd}, {15'h0, n_rst != 0});
    tick(40);
  endtask

  task automatic t_pin();
    hold_reset = 1'b1;
    tick(sysfront_pkg::RST_MIN_OSC - 1);
    hold_reset = 1'b0;
    watch(14);
    chk("short_pulse", 16'h0000, n_rst[15:0]);
    hold_reset = 1'b1;
    tick(sysfront_pkg::RST_MIN_OSC);
    hold_reset = 1'b0;
    watch(14);
    chk("min_pulse", 16'h0001, {15'h0, n_rst != 0});
    hold_reset = 1'b1;
    tick(30);
    chk("pin_reset", 16'h0001, {15'h0, core_reset});
    hold_reset = 1'b0;
    tick(6);
    chk("pin_release", 16'h0000, {15'h0, core_reset});
  endtask

  task automatic end_sim();
    if (n_mismatch == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    {hold_reset, fetch_req, data_acc, ovf, pd_req} = 5'h00;
    pc = 16'h0000;
    do_reset(1'b1, 1'b0);
    t_clock();
    t_fetch(16'h1fff, 16'h0000);
    t_fetch(16'h2000, 16'h0002);
    efs = 1'b0;
    t_fetch(16'h0000, 16'h0000);
    t_wdog(1'b0, 16'h0000);
    do_reset(1'b0, 1'b1);
    t_fetch(16'h0000, 16'h0002);
    t_wdog(1'b1, 16'h0018);
    t_pin();
    end_sim();
  end

  // Cuts a hang short well after the expected run length.
  initial
  begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    end_sim();
  end
endmodule
